// File: core/acp_consts.svh
`ifndef ACP_CONSTS_SVH
`define ACP_CONSTS_SVH
// framing characters
`define ACP_CH_HASH 8'h23
`define ACP_CH_CR 8'h0D
`define ACP_CH_LF 8'h0A
`define ACP_CH_SP 8'h20
`define ACP_CH_0 8'h30
`define ACP_CH_9 8'h39
`define ACP_CH_A 8'h41
`define ACP_CH_F 8'h46
// command field positions after the hash
`define ACP_POS_GROUP 3'h0
`define ACP_POS_SUB 3'h1
`define ACP_POS_CMD 3'h2
`define ACP_POS_SET 3'h3
`define ACP_MAX_FIELD 3'h7
// baud selection code for 9600, also the reset value
`define ACP_BAUD_9600 4'h5
// reply table layout
`define ACP_ROM_DONE 6'h00
`define ACP_ROM_ERR 6'h06
`define ACP_ROM_VER 6'h0D
`define ACP_ROM_PWR 6'h29
`define ACP_ROM_LAST 6'h2F
`endif

// File: core/acp_parser.sv
`timescale 1ns/1ps
`include "acp_consts.svh"
// Overview of operation
// - every reply ends with CR LF
// - setting characters are 0-9 or A-F
// - fewer than two characters: not a command
// - fields: group, subgroup, command, setting
// - long setting strings accepted for some commands (here any command over four characters answers Error)
// - main-port baud code five selects 9600
// - every reply starts with hash
// - action commands answer Done or Error
// - queries answer identifier plus values
// - one space between identifier and value
// - group zero code one enters command mode
// - version query returns model, version, serial
// - power-fail query returns identifier, space, 0/1
// - power-fail flag set by loss, cleared by resets
module acp_parser
  import acp_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  input wire logic TX_READY,
  input wire logic POWER_LOSS,
  output logic [7:0] TX_DATA,
  output logic TX_VALID,
  output logic CMD_MODE,
  output logic [3:0] BAUD_SEL,
  output logic POWER_FAIL,
  output logic READER_RESET
);
  typedef struct packed {
    acp_state_t st;
    logic [2:0] cnt;
    logic [7:0] grp;
    logic [7:0] sub;
    logic [7:0] cmd;
    logic [7:0] set;
    logic bad;
    logic [5:0] addr;
    logic [1:0] tail;
    logic fetch;
    logic [7:0] tx_data;
    logic tx_valid;
    logic cmd_mode;
    logic [3:0] baud;
    logic pfail;
    logic rreset;
    logic loss_m;
    logic loss_s;
  } acp_core_state_t;
  acp_core_state_t s_q;
  acp_core_state_t s_d;
  logic [7:0] rom_data;

  // hex digit test, used for setting and string characters
  function automatic logic is_hex(input logic [7:0] c);
    is_hex = (c >= `ACP_CH_0 && c <= `ACP_CH_9) || (c >= `ACP_CH_A && c <= `ACP_CH_F);
  endfunction

  // hex character to value
  function automatic logic [3:0] hex_val(input logic [7:0] c);
    logic [7:0] v;
    v = (c <= `ACP_CH_9) ? (c - `ACP_CH_0) : (c - `ACP_CH_A + 8'h0A);
    hex_val = v[3:0];
  endfunction

  acp_reply_rom u_rom (
    .clk(SYS_CLK),
    .rst(RST),
    .addr(s_q.addr),
    .data(rom_data)
  );

  always_comb
  begin
    s_d = s_q;
    s_d.rreset = 1'b0;
    // loss pin is asynchronous: two flops before use
    s_d.loss_m = POWER_LOSS;
    s_d.loss_s = s_q.loss_m;
    if (s_q.loss_s)
      s_d.pfail = 1'b1;
    if (s_q.tx_valid && TX_READY)
      s_d.tx_valid = 1'b0;
    unique case (s_q.st)
      ACP_IDLE:
      begin
        if (RX_VALID && RX_DATA == `ACP_CH_HASH)
        begin
          s_d.st = ACP_FIELD;
          s_d.cnt = 3'h0;
          s_d.bad = 1'b0;
          s_d.grp = 8'h00;
          s_d.sub = 8'h00;
          s_d.cmd = 8'h00;
          s_d.set = 8'h00;
        end
      end
      ACP_FIELD:
      begin
        if (RX_VALID)
        begin
          if (RX_DATA == `ACP_CH_HASH)
          begin
            s_d.cnt = 3'h0;
            s_d.bad = 1'b0;
          end
          else if (RX_DATA == `ACP_CH_CR)
          begin
            s_d.st = ACP_SEND;
            s_d.tail = 2'h0;
            s_d.fetch = 1'b1;
            s_d.addr = `ACP_ROM_ERR;
            if (s_q.cnt < 3'h2 || s_q.bad)
              s_d.addr = `ACP_ROM_ERR;
            else if (s_q.grp == `ACP_CH_0 && s_q.cnt == 3'h2 && s_q.sub == 8'h31)
            begin
              s_d.cmd_mode = 1'b1;
              s_d.addr = `ACP_ROM_DONE;
            end
            else if (s_q.grp == `ACP_CH_0 && s_q.cnt == 3'h2 && s_q.sub == `ACP_CH_0)
            begin
              s_d.cmd_mode = 1'b0;
              s_d.addr = `ACP_ROM_DONE;
            end
            else if (s_q.cmd_mode && s_q.cnt == 3'h3 && s_q.grp == 8'h35 && s_q.sub == `ACP_CH_0
                     && s_q.cmd == 8'h35)
              s_d.addr = `ACP_ROM_VER;
            else if (s_q.cmd_mode && s_q.cnt == 3'h3 && s_q.grp == 8'h35 && s_q.sub == 8'h32
                     && s_q.cmd == `ACP_CH_0)
              s_d.addr = `ACP_ROM_PWR;
            else if (s_q.cmd_mode && s_q.cnt == 3'h2 && s_q.grp == 8'h36
                     && (s_q.sub == 8'h33 || s_q.sub == 8'h35))
            begin
              s_d.pfail = s_q.loss_s;
              s_d.rreset = (s_q.sub == 8'h33);
              s_d.addr = `ACP_ROM_DONE;
            end
            else if (s_q.cmd_mode && s_q.cnt == 3'h4 && s_q.grp == 8'h31 && s_q.sub == `ACP_CH_0
                     && s_q.cmd == `ACP_CH_0 && is_hex(s_q.set))
            begin
              s_d.baud = hex_val(s_q.set);
              s_d.addr = `ACP_ROM_DONE;
            end
          end
          else
          begin
            // decode fields by position, then longer strings
            unique case (s_q.cnt)
              `ACP_POS_GROUP: s_d.grp = RX_DATA;
              `ACP_POS_SUB: s_d.sub = RX_DATA;
              `ACP_POS_CMD: s_d.cmd = RX_DATA;
              `ACP_POS_SET: s_d.set = RX_DATA;
              default: s_d.bad = s_q.bad;
            endcase
            if (s_q.cnt >= `ACP_POS_SET && !is_hex(RX_DATA) && s_q.grp != 8'h36)
              s_d.bad = 1'b1;
            if (s_q.cnt != `ACP_MAX_FIELD)
              s_d.cnt = s_q.cnt + 3'h1;
          end
        end
      end
      ACP_SEND:
      begin
        // rom read data is one cycle behind the address
        if (!s_q.tx_valid || TX_READY)
        begin
          if (s_q.fetch)
            s_d.fetch = 1'b0;
          else if (rom_data != 8'h00)
          begin
            s_d.tx_data = rom_data;
            s_d.tx_valid = 1'b1;
            s_d.addr = s_q.addr + 6'h01;
            s_d.fetch = 1'b1;
          end
          else
          begin
            s_d.st = ACP_WAIT;
            s_d.tail = (s_q.addr == `ACP_ROM_PWR + 6'h06) ? 2'h0 : 2'h1;
          end
        end
      end
      ACP_WAIT:
      begin
        // tail: value byte for power query, then CR, then LF
        if (!s_q.tx_valid || TX_READY)
        begin
          s_d.tx_valid = 1'b1;
          s_d.tail = s_q.tail + 2'h1;
          unique case (s_q.tail)
            2'h0: s_d.tx_data = s_q.pfail ? 8'h31 : `ACP_CH_0;
            2'h1: s_d.tx_data = `ACP_CH_CR;
            2'h2:
            begin
              s_d.tx_data = `ACP_CH_LF;
              s_d.st = ACP_IDLE;
            end
            default: s_d.tx_valid = 1'b0;
          endcase
        end
      end
      default: s_d.st = ACP_IDLE;
    endcase
  end

  // all state in one register
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      s_q <= '0;
      s_q.st <= ACP_IDLE;
      s_q.baud <= `ACP_BAUD_9600;
    end
    else
      s_q <= s_d;
  end

  assign TX_DATA = s_q.tx_data;
  assign TX_VALID = s_q.tx_valid;
  assign CMD_MODE = s_q.cmd_mode;
  assign BAUD_SEL = s_q.baud;
  assign POWER_FAIL = s_q.pfail;
  assign READER_RESET = s_q.rreset;
endmodule

// File: core/acp_pkg.sv
package acp_pkg;
  typedef enum logic [3:0] {
    ACP_IDLE = 4'b0001,
    ACP_FIELD = 4'b0010,
    ACP_SEND = 4'b0100,
    ACP_WAIT = 4'b1000
  } acp_state_t;
endpackage

// File: core/acp_reply_rom.sv
`timescale 1ns/1ps
`include "acp_consts.svh"
module acp_reply_rom
  import acp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] addr,
  output logic [7:0] data
);
  typedef struct packed {
    logic [7:0] data;
  } acp_rom_state_t;
  acp_rom_state_t s_q;
  acp_rom_state_t s_d;
  logic [7:0] rom_byte;

  // reply texts; CR/LF appended by the caller
  always_comb
  begin
    unique case (addr)
      6'h00: rom_byte = 8'h23; 6'h01: rom_byte = 8'h44; 6'h02: rom_byte = 8'h6F;
      6'h03: rom_byte = 8'h6E; 6'h04: rom_byte = 8'h65; 6'h05: rom_byte = 8'h00;
      6'h06: rom_byte = 8'h23; 6'h07: rom_byte = 8'h45; 6'h08: rom_byte = 8'h72;
      6'h09: rom_byte = 8'h72; 6'h0A: rom_byte = 8'h6F; 6'h0B: rom_byte = 8'h72;
      6'h0C: rom_byte = 8'h00;
      // version: #Model X1 Ver 1.00 SN000001 (text arbitrary)
      6'h0D: rom_byte = 8'h23; 6'h0E: rom_byte = 8'h4D; 6'h0F: rom_byte = 8'h6F;
      6'h10: rom_byte = 8'h64; 6'h11: rom_byte = 8'h65; 6'h12: rom_byte = 8'h6C;
      6'h13: rom_byte = 8'h20; 6'h14: rom_byte = 8'h58; 6'h15: rom_byte = 8'h31;
      6'h16: rom_byte = 8'h20; 6'h17: rom_byte = 8'h56; 6'h18: rom_byte = 8'h65;
      6'h19: rom_byte = 8'h72; 6'h1A: rom_byte = 8'h20; 6'h1B: rom_byte = 8'h31;
      6'h1C: rom_byte = 8'h2E; 6'h1D: rom_byte = 8'h30; 6'h1E: rom_byte = 8'h30;
      6'h1F: rom_byte = 8'h20; 6'h20: rom_byte = 8'h53; 6'h21: rom_byte = 8'h4E;
      // serial digits, value arbitrary
      6'h22: rom_byte = 8'h30; 6'h23: rom_byte = 8'h30; 6'h24: rom_byte = 8'h30;
      6'h25: rom_byte = 8'h30; 6'h26: rom_byte = 8'h30; 6'h27: rom_byte = 8'h31;
      6'h28: rom_byte = 8'h00;
      // power-fail identifier, value byte appended by the caller
      6'h29: rom_byte = 8'h23; 6'h2A: rom_byte = 8'h50; 6'h2B: rom_byte = 8'h46;
      6'h2C: rom_byte = 8'h4C; 6'h2D: rom_byte = 8'h47; 6'h2E: rom_byte = 8'h20;
      6'h2F: rom_byte = 8'h00;
      default: rom_byte = 8'h00;
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    s_d.data = rom_byte;
  end

  // registered read data, one cycle latency
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign data = s_q.data;
endmodule

// File: tb/acp_host.sv
`timescale 1ns/1ps
module acp_host
(
  input wire logic clk,
  input wire logic slow,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic tx_ready
);
  string got = "";
  initial
  begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end
  // caller frames with hash and CR; idle line shows junk, not the old char
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++)
    begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data = s[i];
      @(negedge clk);
      rx_valid = 1'b0;
      rx_data = ~s[i];
    end
  endtask
  // slow host stalls every other cycle so the reply must stand
  always @(negedge clk)
    tx_ready <= slow ? ~tx_ready : 1'b1;
  always @(posedge clk)
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      got = {got, string'(tx_data)};
  function automatic bit done();
    return got.len() > 0 && got[got.len() - 1] == 8'h0A;
  endfunction
endmodule

// File: tb/acp_parser_bench.sv
`timescale 1ns/1ps
module acp_parser_bench;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic POWER_LOSS = 1'b0;
  logic [7:0] RX_DATA;
  logic [7:0] TX_DATA;
  logic [3:0] BAUD_SEL;
  logic RX_VALID, TX_READY, TX_VALID, CMD_MODE, POWER_FAIL, READER_RESET;
  logic rr_seen = 1'b0;
  logic slow = 1'b0;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  always #20 SYS_CLK = ~SYS_CLK;
  acp_parser acp_parser_i (.*);
  acp_host acp_host_i (.clk(SYS_CLK), .slow(slow), .tx_data(TX_DATA), .tx_valid(TX_VALID),
    .rx_data(RX_DATA), .rx_valid(RX_VALID), .tx_ready(TX_READY));
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input bit ok, input string m);
    total_checks++;
    if (!ok)
    begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  // bounded wait for the closing LF, then a gap before the next command
  task automatic cmd(input string c, input string exp);
    acp_host_i.got = "";
    acp_host_i.send(c);
    for (int k = 0; k < 300 && !acp_host_i.done(); k++)
      @(negedge SYS_CLK);
    repeat (2) @(negedge SYS_CLK);
    if (exp != "")
      check(acp_host_i.got == exp, "reply");
  endtask
  task automatic t_mode();
    cmd("#1005\r", "#Error\r\n");
    cmd("zz#5#01\r", "#Done\r\n");
    check(CMD_MODE === 1'b1, "command mode");
    cmd("#0\r", "");
    check(acp_host_i.got != "#Done\r\n" && CMD_MODE === 1'b1, "short");
  endtask
  task automatic t_baud();
    byte ch[4] = '{8'h30, 8'h39, 8'h41, 8'h46};
    logic [3:0] v[4] = '{4'h0, 4'h9, 4'hA, 4'hF};
    slow = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      cmd({"#100", string'(ch[i]), "\r"}, "#Done\r\n");
      check(BAUD_SEL === v[i], "baud");
    end
    cmd("#100G\r", "#Error\r\n");
    cmd("#100a\r", "#Error\r\n");
    check(BAUD_SEL === 4'hF, "baud kept");
    cmd("#1005\r", "#Done\r\n");
    check(BAUD_SEL === 4'h5, "baud 9600");
    slow = 1'b0;
  endtask
  task automatic t_query();
    cmd("#505\r", "#Model X1 Ver 1.00 SN000001\r\n");
    check(acp_host_i.got.len() > 8 && acp_host_i.got[0] == 8'h23, "version");
    check(acp_host_i.got.substr(acp_host_i.got.len() - 2, acp_host_i.got.len() - 1) == "\r\n", "eol");
  endtask
  task automatic lose_power();
    POWER_LOSS = 1'b1;
    repeat (6) @(negedge SYS_CLK);
    POWER_LOSS = 1'b0;
    repeat (6) @(negedge SYS_CLK);
  endtask
  task automatic t_power();
    cmd("#520\r", "#PFLG 0\r\n");
    lose_power();
    check(POWER_FAIL === 1'b1, "flag set");
    cmd("#520\r", "#PFLG 1\r\n");
    cmd("#65\r", "#Done\r\n");
    check(POWER_FAIL === 1'b0, "flag clear");
    lose_power();
    check(rr_seen === 1'b0, "no early reader reset");
    cmd("#63\r", "#Done\r\n");
    check(POWER_FAIL === 1'b0 && rr_seen === 1'b1, "reader reset");
  endtask
  // hang guard, also notes the one-cycle reader reset pulse
  always @(posedge SYS_CLK)
  begin
    cycles++;
    if (READER_RESET === 1'b1)
      rr_seen = 1'b1;
    if (cycles == 10000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (4) @(negedge SYS_CLK);
    RST = 1'b0;
    check(CMD_MODE === 1'b0 && BAUD_SEL === 4'h5 && POWER_FAIL === 1'b0, "reset");
    t_mode();
    t_baud();
    t_query();
    t_power();
    cmd("#00\r", "#Done\r\n");
    check(CMD_MODE === 1'b0, "data mode");
    wrap_up();
  end
endmodule

// File: tb/acp_parser_monitor.sv
`timescale 1ns/1ps
module acp_parser_monitor
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  input wire logic TX_READY,
  input wire logic POWER_LOSS,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  input wire logic CMD_MODE,
  input wire logic [3:0] BAUD_SEL,
  input wire logic POWER_FAIL,
  input wire logic READER_RESET
);
  logic [7:0] last_q;
  logic first_q;
  logic armed_q;
  logic [2:0] cnt_q;
  wire go = TX_VALID && TX_READY;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  // last sent char, start of reply, chars since hash (saturates, only >=2 matters)
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      last_q <= 8'h00;
      first_q <= 1'b1;
      armed_q <= 1'b0;
      cnt_q <= 3'h0;
    end
    else
    begin
      if (go)
      begin
        last_q <= TX_DATA;
        first_q <= TX_DATA == 8'h0A;
      end
      if (RX_VALID && !TX_VALID)
      begin
        armed_q <= RX_DATA == 8'h23 || (armed_q && RX_DATA != 8'h0D);
        cnt_q <= RX_DATA == 8'h23 ? 3'h0 : cnt_q + {2'h0, cnt_q != 3'h7};
      end
    end
  end
  AST_TX_HOLD: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("reply char changed before accepted");
  AST_REPLY_HASH: assert property (TX_VALID && first_q |-> TX_DATA == 8'h23)
    else $error("reply does not open with hash");
  AST_CR_LF: assert property (go && TX_DATA == 8'h0A |-> last_q == 8'h0D)
    else $error("line feed not after carriage return");
  AST_LF_FOLLOWS: assert property (go && TX_DATA == 8'h0D |-> ##[1:5] TX_VALID && TX_DATA == 8'h0A)
    else $error("no line feed after carriage return");
  AST_ANSWER: assert property (RX_VALID && RX_DATA == 8'h0D && armed_q && cnt_q >= 3'h2 && !TX_VALID
    |-> ##[1:8] TX_VALID && TX_DATA == 8'h23)
    else $error("command got no reply");
  AST_BAUD_RESET: assert property ($past(RST) |-> BAUD_SEL == 4'h5 && !CMD_MODE && !POWER_FAIL)
    else $error("bad state after reset");
  AST_FLAG_SET: assert property ($rose(POWER_FAIL)
    |-> $past(POWER_LOSS, 2) || $past(POWER_LOSS, 3) || $past(POWER_LOSS, 4))
    else $error("flag set without power loss");
  AST_RR_PULSE: assert property (READER_RESET |=> !READER_RESET)
    else $error("reader reset longer than one cycle");
  cover property ($rose(CMD_MODE));
  cover property ($rose(POWER_FAIL));
  cover property (go && TX_DATA == 8'h0A);
endmodule
bind acp_parser acp_parser_monitor acp_parser_monitor_i (.SYS_CLK, .RST, .RX_DATA, .RX_VALID, .TX_READY,
  .POWER_LOSS, .TX_DATA, .TX_VALID, .CMD_MODE, .BAUD_SEL, .POWER_FAIL, .READER_RESET);
